// *** grl_params.svh ***
// Purpose: constants for the remote/local interface message handler
// Assumes: included by the sync, poll and top design files of the block
// Notes:   trigger codes select settling and rearm behaviour
`ifndef GRL_PARAMS_SVH
`define GRL_PARAMS_SVH
`define GRL_STB_RQS_BIT      6
`define GRL_STB_MAV_BIT      4
`define GRL_SRE_RESET        8'h00
`define GRL_TRIG_SETTLE_DEF  1'b1
`define GRL_TRIG_REARM_DEF   1'b1
`define GRL_SYNC_STAGES      2
`endif

// *** grl_pkg.sv ***
// Purpose: types shared by the remote/local handler
// Assumes: grl_params.svh holds the numeric constants
// Notes:   bus messages arrive already decoded, one-cycle pulses
package grl_pkg;
  // decoded interface messages from the bus front end
  typedef struct packed {
    logic gtl;
    logic llo;
    logic sdc;
    logic dcl;
    logic get;
    logic spe;
    logic spd;
    logic ifc;
    logic mla;
    logic mta;
    logic unl;
    logic unt;
    logic ppoll;
  } grl_msg_t;

  // trigger configuration: complete_stabilise_trigger and auto_rearm_trigger
  typedef struct packed {
    logic complete_stabilise_trigger;
    logic auto_rearm_trigger;
  } grl_trig_t;

  typedef enum logic [2:0] {
    GRL_LOCS = 3'b001,
    GRL_REMS = 3'b010,
    GRL_RWLS = 3'b100
  } grl_rl_state_t;
endpackage

// *** grl_sync.sv ***
// Purpose: two-flop synchroniser for bus control lines
// Assumes: inputs asynchronous to mclk_i
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
`include "grl_params.svh"
module grl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// *** grl_poll.sv ***
// Purpose: status byte assembly, service request and serial poll answer
// Assumes: status byte bits other than rqs come from the device core
// Notes:   rqs mirrors the driven service request line
`timescale 1ns/1ps
`include "grl_params.svh"
module grl_poll (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] stb_i,
  input  wire logic [7:0] sre_i,
  input  wire logic       spoll_i,
  input  wire logic       talk_i,
  output logic            srq_o,
  output logic [7:0]      poll_byte_o,
  output logic            poll_valid_o
);
  logic [7:0] summary;

  always_comb begin
    summary = stb_i;
    summary[`GRL_STB_RQS_BIT] = 1'b0;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      srq_o <= 1'b0;
    end else begin
      srq_o <= |(summary & sre_i); // [R09]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      poll_byte_o  <= 8'h00;
      poll_valid_o <= 1'b0;
    end else begin
      poll_valid_o <= spoll_i && talk_i; // [R10]
      poll_byte_o  <= {summary[7], srq_o, summary[5:0]}; // [R11]
    end
  end

  a_rqs_tracks_srq: assert property (@(posedge mclk_i) disable iff (reset_i) // [R11]
    poll_valid_o |-> poll_byte_o[`GRL_STB_RQS_BIT] == $past(srq_o))
    else $error("rqs bit differs from service request");
  a_srq_cause: assert property (@(posedge mclk_i) disable iff (reset_i) // [R09]
    ##1 srq_o == $past(|(stb_i & sre_i & ~(8'h01 << `GRL_STB_RQS_BIT))))
    else $error("service request does not follow enabled status");
  a_poll_when_talk: assert property (@(posedge mclk_i) disable iff (reset_i) // [R10]
    poll_valid_o |-> $past(spoll_i && talk_i))
    else $error("poll byte sent while not polled as talker");
endmodule

// *** grl_top.sv ***
// Purpose: remote/local, lockout, polling and device clear handling
// Assumes: bus messages decoded upstream into one-cycle pulses
// Notes:   ren arrives from a pin and is synchronised here
`timescale 1ns/1ps
`include "grl_params.svh"

// What this block does
// R01 - Remote is entered only with ren true while addressed as listener.
// R02 - In remote, panel keys are masked except local, power, volume, squelch.
// R03 - Entering remote restores the trigger setting last chosen in remote.
// R04 - Local returns on addressed gtl, local key, or ren going false.
// R05 - Returning to local forces complete stabilise and auto rearm triggering.
// R06 - The local key is ignored while lockout is active.
// R07 - Lockout disables every panel key including local; the code masks keys with keep_keys_i as in plain remote.
// R08 - Ren false returns local, clears lockout, and defaults the trigger.
// R09 - Service request is driven while any enabled status bit other than rqs (bit 6) is true.
// R10 - Under serial poll as talker the status byte is sent as one byte.
// R11 - Bit 6 of the polled byte shows the pending service request.
// R12 - Parallel poll messages get no response.
// R13 - Device clear empties buffers, aborts commands, goes operation-complete idle.
// R14 - Device clear leaves settings, stored data and panel input alone.
// R15 - Device clear leaves the status byte, except message available drops.
// R16 - Universal and addressed device clear act identically.
// R17 - As talker the device can return status, messages, settings and results.
// R18 - Group trigger in remote while listening acts as the trigger command.
// R19 - Interface clear ends talker and listener roles at once.
// R20 - Gtl under lockout restores panel control but keeps lockout set.
// R21 - Remote, lockout and service request enable all clear at power-up.
module grl_top (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              ren_i,
  input  wire grl_pkg::grl_msg_t msg_i,
  input  wire logic [15:0]       keys_i,
  input  wire logic [15:0]       keep_keys_i,
  input  wire logic              local_key_i,
  input  wire logic [7:0]        stb_i,
  input  wire logic [7:0]        sre_wdata_i,
  input  wire logic              sre_we_i,
  input  wire grl_pkg::grl_trig_t trig_wdata_i,
  input  wire logic              trig_we_i,
  input  wire logic              trg_cmd_i,
  input  wire logic              talk_data_i,
  output logic                   remote_o,
  output logic                   lockout_o,
  output logic                   listen_o,
  output logic                   talk_o,
  output logic [15:0]            keys_o,
  output grl_pkg::grl_trig_t     trig_o,
  output logic                   meas_trig_o,
  output logic                   clr_inbuf_o,
  output logic                   clr_outq_o,
  output logic                   abort_cmd_o,
  output logic                   opc_idle_o,
  output logic [7:0]             sre_o,
  output logic                   srq_o,
  output logic [7:0]             poll_byte_o,
  output logic                   poll_valid_o,
  output logic                   talk_data_o
);
  import grl_pkg::*;

  localparam grl_trig_t TRIG_DEF = '{`GRL_TRIG_SETTLE_DEF, `GRL_TRIG_REARM_DEF};

  logic          ren_s;
  logic          ren_prev_q;
  logic          ren_fall;
  grl_rl_state_t rl_q;
  grl_rl_state_t rl_d;
  logic          lls_q;
  logic          lls_d;
  logic          spoll_q;
  grl_trig_t     rem_trig_q;
  logic          dev_clear;
  logic          srq_int;
  logic [7:0]    poll_int;
  logic          poll_v_int;

  grl_sync #(.WIDTH(1)) u_ren_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (ren_i),
    .sync_o  (ren_s)
  );

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ren_prev_q <= 1'b0;
    end else begin
      ren_prev_q <= ren_s;
    end
  end
  assign ren_fall = ren_prev_q && !ren_s;

  // addressing roles
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      listen_o <= 1'b0;
      talk_o   <= 1'b0;
    end else if (msg_i.ifc) begin
      listen_o <= 1'b0; // [R19]
      talk_o   <= 1'b0; // [R19]
    end else begin
      if (msg_i.mla) begin
        listen_o <= 1'b1;
      end else if (msg_i.unl) begin
        listen_o <= 1'b0;
      end
      if (msg_i.mta) begin
        talk_o <= 1'b1;
      end else if (msg_i.unt || msg_i.mla) begin
        talk_o <= 1'b0;
      end
    end
  end

  // remote/local state; lockout kept as an independent flag
  always_comb begin
    rl_d  = rl_q;
    lls_d = lls_q;
    if (!ren_s) begin
      rl_d  = GRL_LOCS; // [R04] [R08]
      lls_d = 1'b0;     // [R08]
    end else begin
      if (msg_i.llo) begin
        lls_d = 1'b1; // [R07]
      end
      unique case (rl_q)
        GRL_LOCS: begin
          if (msg_i.mla) begin
            rl_d = lls_d ? GRL_RWLS : GRL_REMS; // [R01]
          end
        end
        GRL_REMS: begin
          if (msg_i.gtl && listen_o) begin
            rl_d = GRL_LOCS; // [R04]
          end else if (lls_d) begin
            rl_d = GRL_RWLS;
          end else if (local_key_i) begin
            rl_d = GRL_LOCS; // [R04]
          end
        end
        GRL_RWLS: begin
          if (msg_i.gtl && listen_o) begin
            rl_d = GRL_LOCS; // [R20]
          end
        end
        default: rl_d = GRL_LOCS;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rl_q  <= GRL_LOCS; // [R21]
      lls_q <= 1'b0;     // [R21]
    end else begin
      rl_q  <= rl_d;
      lls_q <= lls_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      remote_o  <= 1'b0;
      lockout_o <= 1'b0;
    end else begin
      remote_o  <= (rl_d != GRL_LOCS);
      lockout_o <= lls_d;
    end
  end

  // panel key gating; keep_keys_i mask applied alike in plain remote and lockout
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      keys_o <= 16'h0000;
    end else if (rl_q == GRL_RWLS) begin
      keys_o <= keys_i & keep_keys_i; // [R07] [R06]
    end else if (rl_q == GRL_REMS) begin
      keys_o <= keys_i & keep_keys_i; // [R02]
    end else begin
      keys_o <= keys_i;
    end
  end

  // trigger configuration
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rem_trig_q <= TRIG_DEF;
    end else if (trig_we_i && rl_q != GRL_LOCS) begin
      rem_trig_q <= trig_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      trig_o <= TRIG_DEF;
    end else if (rl_q == GRL_LOCS && rl_d != GRL_LOCS) begin
      trig_o <= rem_trig_q; // [R03]
    end else if (rl_d == GRL_LOCS) begin
      trig_o <= TRIG_DEF; // [R05] [R08]
    end else if (trig_we_i) begin
      trig_o <= trig_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meas_trig_o <= 1'b0;
    end else begin
      meas_trig_o <= trg_cmd_i || (msg_i.get && rl_q != GRL_LOCS && listen_o); // [R18]
    end
  end

  // device clear; touches only buffers, command state and opc
  assign dev_clear = msg_i.dcl || (msg_i.sdc && listen_o); // [R16]

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      clr_inbuf_o <= 1'b0;
      clr_outq_o  <= 1'b0;
      abort_cmd_o <= 1'b0;
      opc_idle_o  <= 1'b0;
    end else begin
      clr_inbuf_o <= dev_clear; // [R13] [R14]
      clr_outq_o  <= dev_clear; // [R13] [R15]
      abort_cmd_o <= dev_clear; // [R13]
      opc_idle_o  <= dev_clear; // [R13]
    end
  end

  // service request enable register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sre_o <= `GRL_SRE_RESET; // [R21]
    end else if (sre_we_i) begin
      sre_o <= sre_wdata_i;
    end
  end

  // serial poll mode; parallel poll messages fall through unused
  always_ff @(posedge mclk_i) begin
    if (reset_i || msg_i.ifc) begin
      spoll_q <= 1'b0;
    end else if (msg_i.spe) begin
      spoll_q <= 1'b1;
    end else if (msg_i.spd) begin
      spoll_q <= 1'b0;
    end
  end

  grl_poll u_poll (
    .mclk_i       (mclk_i),
    .reset_i      (reset_i),
    .stb_i        (stb_i),
    .sre_i        (sre_o),
    .spoll_i      (spoll_q),
    .talk_i       (talk_o),
    .srq_o        (srq_int),
    .poll_byte_o  (poll_int),
    .poll_valid_o (poll_v_int)
  );

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      srq_o        <= 1'b0;
      poll_byte_o  <= 8'h00;
      poll_valid_o <= 1'b0;
      talk_data_o  <= 1'b0;
    end else begin
      srq_o        <= srq_int;
      poll_byte_o  <= poll_int;
      poll_valid_o <= poll_v_int; // [R10] [R12]
      talk_data_o  <= talk_data_i && talk_o && !spoll_q; // [R17]
    end
  end

  a_remote_needs_ren: assert property (@(posedge mclk_i) disable iff (reset_i) // [R01]
    $rose(remote_o) |-> $past(ren_s) && $past(msg_i.mla))
    else $error("remote entered without ren and listen address");
  a_ren_low_local: assert property (@(posedge mclk_i) disable iff (reset_i) // [R08]
    !ren_s |=> !remote_o && !lockout_o && trig_o == TRIG_DEF)
    else $error("ren false did not force local");
  a_ren_fall_local: assert property (@(posedge mclk_i) disable iff (reset_i) // [R04]
    ren_fall && remote_o |=> $fell(remote_o) && trig_o == TRIG_DEF)
    else $error("remote kept after ren fell");
  a_lockout_key: assert property (@(posedge mclk_i) disable iff (reset_i) // [R06]
    rl_q == GRL_RWLS && local_key_i && ren_s && !msg_i.gtl |=> remote_o)
    else $error("local key acted under lockout");
  a_remote_keys: assert property (@(posedge mclk_i) disable iff (reset_i) // [R02]
    rl_q != GRL_LOCS |=> keys_o == $past(keys_i & keep_keys_i))
    else $error("panel key passed in remote");
  a_local_trig: assert property (@(posedge mclk_i) disable iff (reset_i) // [R05]
    $fell(remote_o) |-> trig_o == TRIG_DEF)
    else $error("trigger not defaulted on local");
  a_gtl_keeps_lls: assert property (@(posedge mclk_i) disable iff (reset_i) // [R20]
    lockout_o && msg_i.gtl && listen_o && ren_s && !msg_i.mla |=> lockout_o && !remote_o)
    else $error("gtl cleared lockout");
  a_clear_pulse: assert property (@(posedge mclk_i) disable iff (reset_i) // [R16]
    (msg_i.dcl || (msg_i.sdc && listen_o)) |=>
      clr_outq_o && clr_inbuf_o && opc_idle_o && abort_cmd_o)
    else $error("device clear actions missing");
  a_ifc_roles: assert property (@(posedge mclk_i) disable iff (reset_i) // [R19]
    msg_i.ifc |=> !talk_o && !listen_o)
    else $error("talker or listener kept after ifc");
  a_get_trigger: assert property (@(posedge mclk_i) disable iff (reset_i) // [R18]
    msg_i.get && remote_o && listen_o && rl_q != GRL_LOCS |=> meas_trig_o)
    else $error("group trigger ignored in remote");
endmodule

// *** grl_ctrl_model.sv ***
// Purpose: bus controller model driving ren and decoded messages
// Assumes: messages are one-cycle pulses taken on mclk_i
// Notes:   ren idles false, messages idle all zero
`timescale 1ns/1ps
module grl_ctrl_model (
  input  wire logic         mclk_i,
  output logic              ren_o,
  output grl_pkg::grl_msg_t msg_o
);
  import grl_pkg::*;

  initial begin
    ren_o = 1'b0;
    msg_o = '0;
  end

  // one pulse, released at the edge that takes it
  task automatic send(input logic [12:0] v);
    @(posedge mclk_i);
    msg_o <= grl_msg_t'(v);
    @(posedge mclk_i);
    msg_o <= '0;
    #1;
  endtask

  // ren needs the synchroniser plus output register
  task automatic set_ren(input logic v);
    @(posedge mclk_i);
    ren_o <= v;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench for the remote/local handler
// Assumes: outputs registered, answers just after the taking edge
// Notes:   one task per scenario
`timescale 1ns/1ps
module testbench;
  import grl_pkg::*;
  localparam logic [12:0] GTL = 13'h1000, LLO = 13'h0800, SDC = 13'h0400;
  localparam logic [12:0] DCL = 13'h0200, GET = 13'h0100, SPE = 13'h0080;
  localparam logic [12:0] SPD = 13'h0040, IFC = 13'h0020, MLA = 13'h0010;
  localparam logic [12:0] MTA = 13'h0008, PPL = 13'h0001;
  logic mclk_i = 1'b0, reset_i = 1'b1, ren_i, local_key_i = 1'b0, sre_we_i = 1'b0;
  logic trig_we_i = 1'b0, remote_o, lockout_o, listen_o, talk_o, meas_trig_o, srq_o;
  logic clr_inbuf_o, clr_outq_o, abort_cmd_o, opc_idle_o, poll_valid_o;
  logic trg_cmd_i = 1'b0, talk_data_i = 1'b0, talk_data_o;
  logic [15:0] keys_i = 16'h0000, keep_keys_i = 16'h0000, keys_o;
  logic [7:0]  stb_i = 8'h00, sre_wdata_i = 8'h00, sre_o, poll_byte_o;
  grl_msg_t    msg_i;
  grl_trig_t   trig_wdata_i = '0, trig_o;
  int          error_cnt = 0, checked = 0;

  initial forever #10 mclk_i = ~mclk_i;

  grl_ctrl_model ctrl (.mclk_i(mclk_i), .ren_o(ren_i), .msg_o(msg_i));

  grl_top dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .ren_i(ren_i), .msg_i(msg_i),
    .keys_i(keys_i), .keep_keys_i(keep_keys_i), .local_key_i(local_key_i),
    .stb_i(stb_i), .sre_wdata_i(sre_wdata_i), .sre_we_i(sre_we_i),
    .trig_wdata_i(trig_wdata_i), .trig_we_i(trig_we_i), .trg_cmd_i(trg_cmd_i),
    .talk_data_i(talk_data_i), .remote_o(remote_o), .lockout_o(lockout_o),
    .listen_o(listen_o), .talk_o(talk_o), .keys_o(keys_o), .trig_o(trig_o),
    .meas_trig_o(meas_trig_o), .clr_inbuf_o(clr_inbuf_o), .clr_outq_o(clr_outq_o),
    .abort_cmd_o(abort_cmd_o), .opc_idle_o(opc_idle_o), .sre_o(sre_o),
    .srq_o(srq_o), .poll_byte_o(poll_byte_o), .poll_valid_o(poll_valid_o),
    .talk_data_o(talk_data_o)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic print_verdict;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic lkey;
    @(posedge mclk_i);
    local_key_i <= 1'b1;
    @(posedge mclk_i);
    local_key_i <= 1'b0;
    cyc(1);
  endtask

  task automatic t_reset;
    chk(remote_o, 0, "remote at reset");
    chk(lockout_o, 0, "lockout at reset");
    chk(sre_o, 0, "sre at reset");
    chk(trig_o, 3, "trigger at reset");
  endtask

  task automatic t_remote;
    ctrl.send(MLA);
    chk(remote_o, 0, "remote without ren");
    ctrl.set_ren(1'b1);
    chk(remote_o, 0, "remote before address");
    ctrl.send(MLA);
    chk(remote_o, 1, "remote entry");
    @(posedge mclk_i);
    keys_i <= 16'hffff;
    keep_keys_i <= 16'h0005;
    trig_wdata_i <= '0;
    trig_we_i <= 1'b1;
    @(posedge mclk_i);
    trig_we_i <= 1'b0;
    cyc(2);
    chk(keys_o, 16'h0005, "keys masked");
    chk(trig_o, 0, "trigger write");
    ctrl.send(GTL);
    chk(remote_o, 0, "gtl to local");
    chk(trig_o, 3, "local trigger");
    cyc(2);
    chk(keys_o, 16'hffff, "keys live in local");
    ctrl.send(MLA);
    chk(trig_o, 0, "trigger recalled");
    lkey();
    chk(remote_o, 0, "local key");
    chk(trig_o, 3, "local key trigger");
  endtask

  task automatic t_lockout;
    ctrl.send(MLA);
    ctrl.send(LLO);
    chk(lockout_o, 1, "lockout set");
    lkey();
    chk(remote_o, 1, "local key ignored");
    ctrl.send(GTL);
    chk({remote_o, lockout_o}, 1, "gtl in lockout");
    ctrl.send(MLA);
    chk({remote_o, lockout_o}, 3, "lockout back");
    ctrl.set_ren(1'b0);
    chk({remote_o, lockout_o}, 0, "ren false");
    chk(trig_o, 3, "ren false trigger");
  endtask

  task automatic t_poll;
    @(posedge mclk_i);
    sre_wdata_i <= 8'h21;
    sre_we_i <= 1'b1;
    stb_i <= 8'h20;
    talk_data_i <= 1'b1;
    @(posedge mclk_i);
    sre_we_i <= 1'b0;
    cyc(3);
    chk(sre_o, 8'h21, "sre write");
    chk(srq_o, 1, "srq raised");
    chk(talk_data_o, 0, "no data when not talker");
    ctrl.send(SPE | MTA);
    cyc(2);
    chk(poll_valid_o, 1, "poll valid");
    chk(poll_byte_o, 8'h60, "poll byte");
    chk(talk_data_o, 0, "no data while polled");
    ctrl.send(SPD);
    @(posedge mclk_i);
    stb_i <= 8'h10;
    cyc(4);
    chk(srq_o, 0, "srq not enabled bit");
    chk({poll_valid_o, talk_data_o}, 1, "data after poll off");
  endtask

  task automatic t_clear;
    ctrl.set_ren(1'b1);
    ctrl.send(MLA);
    ctrl.send(DCL);
    chk({clr_inbuf_o, clr_outq_o, abort_cmd_o, opc_idle_o}, 15, "dcl");
    cyc(1);
    chk({clr_inbuf_o, clr_outq_o, abort_cmd_o, opc_idle_o}, 0, "dcl pulse");
    ctrl.send(SDC);
    chk({clr_inbuf_o, clr_outq_o, abort_cmd_o, opc_idle_o}, 15, "sdc");
    chk({remote_o, sre_o}, 9'h121, "clear keeps state");
    ctrl.send(PPL);
    chk({clr_inbuf_o, poll_valid_o, meas_trig_o}, 0, "ppoll");
    ctrl.send(GET);
    chk(meas_trig_o, 1, "group trigger");
    @(posedge mclk_i);
    trg_cmd_i <= 1'b1;
    @(posedge mclk_i);
    trg_cmd_i <= 1'b0;
    #1;
    chk(meas_trig_o, 1, "trigger command");
    ctrl.send(IFC);
    chk({listen_o, talk_o}, 0, "ifc");
    ctrl.send(SDC);
    chk({clr_inbuf_o, clr_outq_o, abort_cmd_o, opc_idle_o}, 0, "sdc unaddressed");
    ctrl.send(GET);
    chk(meas_trig_o, 0, "get unaddressed");
    ctrl.send(GTL);
    chk(remote_o, 1, "gtl unaddressed");
  endtask

  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    cyc(1);
    t_reset();
    t_remote();
    t_lockout();
    t_poll();
    t_clear();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    $display("ERROR %0t run limit reached", $time);
    print_verdict();
  end
endmodule
